/* hw/sec_params.svh */
`ifndef SEC_PARAMS_SVH
`define SEC_PARAMS_SVH

// register byte addresses
`define SEC_ADDR_LATCH     8'h00
`define SEC_ADDR_CMASK     8'h04
`define SEC_ADDR_PEND      8'h08
`define SEC_ADDR_PMASK     8'h0c
`define SEC_ADDR_PSTATE    8'h10
`define SEC_ADDR_WAKE      8'h14
`define SEC_ADDR_ASSIGN0   8'h18
`define SEC_ADDR_ASSIGN1   8'h1c
`define SEC_ADDR_ASSIGN2   8'h20
`define SEC_ADDR_ASSIGN3   8'h24
`define SEC_ADDR_CTRL      8'h28

// sizes
`define SEC_NSRC           29
`define SEC_NGP            9
`define SEC_NCLS           16
`define SEC_GP_BASE        7

// sources 1 and 21..26 do not exist
`define SEC_SRC_VALID      29'h181f_fffd
// classes 0..4 cannot be masked
`define SEC_NOMASK         16'h001f

// reset values
`define SEC_CMASK_RST      16'h0000
`define SEC_PMASK_RST      29'h000_0000
`define SEC_WAKE_RST       29'h000_0000
`define SEC_GIE_RST        1'b0
// default source-to-input routing, one nibble per source, 0 means input 7
`define SEC_ASSIGN_RST     128'h0008_7000_0006_6554_4433_3322_1111_0000

`endif

/* hw/sec_pkg.sv */
`default_nettype none
package sec_pkg;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } sec_bus_s;

    typedef struct packed {
        logic       req;
        logic [3:0] cls;
    } sec_svc_s;
endpackage
`default_nettype wire

/* hw/sec_ctrl.sv */
// What this block does
// R01: software picks each source's target input
// R02: default routing loaded at reset
// R03: sixteen-bit latch, mask and pending registers
// R04: latch set by hardware, cleared on acceptance
// R05: mask bit set lets class be serviced
// R06: global enable gates general-purpose inputs
// R07: pending marks active or nested events
// R08: three 32-bit per-source control registers
// R09: clear source mask bit blocks source
// R10: source state reads live source level
// R11: enabled source wakes powered-down core
// R12: shared input tolerates overlapping pulses
// R13: pending bit acknowledges routing stage
// R14: two-cycle rising edge sets latch
// R15: pending set clears latch, rearms edge
// R16: pending no sooner than three cycles
// R17: fixed priority, lowest index wins
// R18: higher priority preempts active service
// R19: input is OR of unmasked mapped sources
// R20: reserved source bits read zero, inert
`include "sec_params.svh"
`default_nettype none
module sec_ctrl
(
    input  wire logic              ref_clk_i,
    input  wire logic              rst_b_i,
    input  wire sec_pkg::sec_bus_s bus_i,
    output logic [31:0]            rdata_o,
    input  wire logic              supervisor_i,
    input  wire logic [28:0]       src_i,
    input  wire logic [6:0]        ded_evt_i,
    input  wire logic              global_irq_on_instr_i,
    input  wire logic              global_irq_off_instr_i,
    input  wire logic              accept_i,
    input  wire logic              return_i,
    input  wire logic              powered_down_i,
    output sec_pkg::sec_svc_s      svc_o,
    output logic [8:0]             gp_ack_o,
    output logic                   wake_o
);
    import sec_pkg::*;

    logic        rst_s1;
    logic        rst_n;
    logic [15:0] core_event_latch;
    logic [15:0] core_event_mask;
    logic [15:0] core_event_pending;
    logic [28:0] peripheral_source_mask;
    logic [28:0] peripheral_wakeup_enable;
    logic [3:0]  target [0:28];
    logic        gie;
    logic [8:0]  gp_raw;
    logic [15:0] raw;
    logic [15:0] raw_q;
    logic [15:0] raw_qq;
    logic [15:0] edge_det;
    logic [15:0] eff_mask;
    logic [15:0] elig;
    logic [15:0] higher;
    logic        svc_req;
    logic [3:0]  svc_cls;
    logic        acc_fire;
    logic [15:0] acc_bit;
    logic [15:0] ret_bit;
    logic [28:0] src_live;
    logic [31:0] next_rdata;
    logic        core_ok;
    logic [31:0] assign_word [0:3];

    // reset released through two flops
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // R20: reserved ids masked off
    assign src_live = src_i & `SEC_SRC_VALID;
    assign core_ok  = supervisor_i;

    // R01: per-source target, R02: default map
    genvar s;
    generate
        for (s = 0; s < `SEC_NSRC; s++)
        begin : g_tgt
            always_ff @(posedge ref_clk_i or negedge rst_n)
            begin
                if (!rst_n)
                    target[s] <= 4'(`SEC_ASSIGN_RST >> (4 * s));
                else if (bus_i.wr && core_ok
                         && bus_i.addr == `SEC_ADDR_ASSIGN0
                            + 8'(4 * (s / 8)))
                    target[s] <= bus_i.wdata[4 * (s % 8) +: 4];
            end
        end
    endgenerate

    // R19: or of unmasked sources, R09 mask gate
    genvar g;
    generate
        for (g = 0; g < `SEC_NGP; g++)
        begin : g_gp
            logic [28:0] hit;
            always_comb
            begin
                for (int k = 0; k < `SEC_NSRC; k++)
                    hit[k] = src_live[k] && peripheral_source_mask[k]
                             && target[k] == 4'(g);
            end
            assign gp_raw[g] = |hit;
        end
    endgenerate

    // R13: pending bits seen as the acknowledgement
    assign gp_ack_o = core_event_pending[15:7];

    // R08: per-source control registers
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            peripheral_source_mask   <= `SEC_PMASK_RST;
            peripheral_wakeup_enable <= `SEC_WAKE_RST;
        end
        else if (bus_i.wr && core_ok)
        begin
            if (bus_i.addr == `SEC_ADDR_PMASK)
                peripheral_source_mask <= bus_i.wdata[28:0]
                                          & `SEC_SRC_VALID;
            if (bus_i.addr == `SEC_ADDR_WAKE)
                peripheral_wakeup_enable <= bus_i.wdata[28:0]
                                            & `SEC_SRC_VALID;
        end
    end

    // R11: wakeup request while powered down
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            wake_o <= 1'b0;
        else
            wake_o <= powered_down_i
                      && |(src_live & peripheral_wakeup_enable);
    end

    // R14: edge seen after two clocks
    assign raw = {gp_raw, ded_evt_i};
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            raw_q  <= 16'h0000;
            raw_qq <= 16'h0000;
        end
        else
        begin
            raw_q  <= raw;
            raw_qq <= raw_q;
        end
    end
    assign edge_det = raw_q & ~raw_qq;

    // R06: global enable instructions
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            gie <= `SEC_GIE_RST;
        else if (global_irq_on_instr_i)
            gie <= 1'b1;
        else if (global_irq_off_instr_i)
            gie <= 1'b0;
        else if (bus_i.wr && core_ok && bus_i.addr == `SEC_ADDR_CTRL)
            gie <= bus_i.wdata[0];
    end

    // R05: core mask, R03 sixteen classes
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            core_event_mask <= `SEC_CMASK_RST;
        else if (bus_i.wr && core_ok && bus_i.addr == `SEC_ADDR_CMASK)
            core_event_mask <= bus_i.wdata[15:0];
    end
    assign eff_mask = core_event_mask | `SEC_NOMASK;

    // R17: fixed priority, R18 preempt only above active
    always_comb
    begin
        higher  = 16'h0000;
        svc_cls = 4'h0;
        svc_req = 1'b0;
        for (int k = `SEC_NCLS - 1; k >= 0; k--)
            if (core_event_pending[k])
                higher = 16'((32'h1 << k) - 32'h1);
        if (core_event_pending == 16'h0000)
            higher = 16'hffff;
        elig = core_event_latch & eff_mask & higher
               & {{9{gie}}, 7'h7f};
        for (int k = `SEC_NCLS - 1; k >= 0; k--)
            if (elig[k])
            begin
                svc_cls = 4'(k);
                svc_req = 1'b1;
            end
    end

    assign svc_o.req = svc_req;
    assign svc_o.cls = svc_cls;
    assign acc_fire  = accept_i && svc_req;
    assign acc_bit   = acc_fire ? 16'(32'h1 << svc_cls) : 16'h0000;

    // return retires the highest-priority active level
    always_comb
    begin
        ret_bit = 16'h0000;
        for (int k = `SEC_NCLS - 1; k >= 0; k--)
            if (core_event_pending[k])
                ret_bit = 16'(32'h1 << k);
        if (!return_i)
            ret_bit = 16'h0000;
    end

    // R04: latch, R15 cleared on accept; new edge wins (R12)
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            core_event_latch <= 16'h0000;
        else
            core_event_latch <= (core_event_latch & ~acc_bit) | edge_det;
    end

    // R07: pending set on accept, cleared on return
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            core_event_pending <= 16'h0000;
        else
            core_event_pending <= (core_event_pending & ~ret_bit)
                                  | acc_bit;
    end

    // assignment words rebuilt for readback
    always_comb
    begin
        for (int w = 0; w < 4; w++)
            assign_word[w] = 32'h0000_0000;
        for (int k = 0; k < `SEC_NSRC; k++)
            assign_word[k / 8][4 * (k % 8) +: 4] = target[k];
    end

    // R10: live state; all regs read zero outside supervisor
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (core_ok)
        begin
            case (bus_i.addr)
                `SEC_ADDR_LATCH:   next_rdata = {16'h0, core_event_latch};
                `SEC_ADDR_CMASK:   next_rdata = {16'h0, core_event_mask};
                `SEC_ADDR_PEND:    next_rdata = {16'h0, core_event_pending};
                `SEC_ADDR_PMASK:   next_rdata = {3'h0, peripheral_source_mask};
                `SEC_ADDR_PSTATE:  next_rdata = {3'h0, src_live};
                `SEC_ADDR_WAKE:
                    next_rdata = {3'h0, peripheral_wakeup_enable};
                `SEC_ADDR_ASSIGN0: next_rdata = assign_word[0];
                `SEC_ADDR_ASSIGN1: next_rdata = assign_word[1];
                `SEC_ADDR_ASSIGN2: next_rdata = assign_word[2];
                `SEC_ADDR_ASSIGN3: next_rdata = assign_word[3];
                `SEC_ADDR_CTRL:    next_rdata = {31'h0, gie};
                default:           next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            rdata_o <= 32'h0000_0000;
        else if (bus_i.rd)
            rdata_o <= next_rdata;
        else
            rdata_o <= 32'h0000_0000;
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n);

    latch_on_edge_a: assert property ( // R14
        edge_det != 16'h0000 |=>
            (core_event_latch & $past(edge_det)) == $past(edge_det))
        else $error("edge did not set latch");

    accept_pend_a: assert property ( // R15
        acc_fire |=> core_event_pending[$past(svc_cls)]
                     && !(core_event_latch[$past(svc_cls)]
                          && !$past(edge_det[svc_cls])))
        else $error("accept did not move latch to pending");

    req_from_latch_a: assert property ( // R16
        svc_req |-> core_event_latch[svc_cls]
            && (($past(raw_q) | $past(core_event_latch))
                & (16'h0001 << svc_cls)) != 16'h0000)
        else $error("service request without latched edge");

    src_gate_a: assert property ( // R09
        (src_live & peripheral_source_mask) == 29'h0 |-> gp_raw == 9'h0)
        else $error("masked source reached input");

    state_read_a: assert property ( // R10
        bus_i.rd && core_ok && bus_i.addr == `SEC_ADDR_PSTATE
            |=> rdata_o == {3'h0, $past(src_live)})
        else $error("state readback wrong");

    wake_req_a: assert property ( // R11
        powered_down_i && |(src_live & peripheral_wakeup_enable)
            |=> wake_o)
        else $error("wakeup not raised");

    prio_order_a: assert property ( // R17
        svc_req |-> (elig & 16'((32'h1 << svc_cls) - 32'h1)) == 16'h0)
        else $error("lower priority chosen");

    gie_block_a: assert property ( // R06
        !gie |-> !(svc_req && svc_cls >= 4'h7))
        else $error("general input served while disabled");

    mask_block_a: assert property ( // R05
        svc_req |-> eff_mask[svc_cls])
        else $error("masked class requested");

    nest_only_up_a: assert property ( // R18
        svc_req && core_event_pending != 16'h0 |->
            (core_event_pending & 16'((32'h2 << svc_cls) - 32'h1)) == 16'h0
             || svc_cls == 4'h0)
        else $error("preemption by equal or lower class");

    assign_wr_a: assert property ( // R01
        bus_i.wr && core_ok && bus_i.addr == `SEC_ADDR_ASSIGN0
            |=> target[0] == $past(bus_i.wdata[3:0]))
        else $error("source target not written");

    gie_on_a: assert property ( // R06
        global_irq_on_instr_i |=> gie)
        else $error("global enable not set");

    gie_off_a: assert property ( // R06
        global_irq_off_instr_i && !global_irq_on_instr_i |=> !gie)
        else $error("global enable not cleared");

    ret_clear_a: assert property ( // R07
        return_i && !acc_fire && core_event_pending != 16'h0
            |=> $countones(core_event_pending)
                == $countones($past(core_event_pending)) - 1)
        else $error("return did not retire one level");

    wake_idle_a: assert property ( // R11
        !powered_down_i |=> !wake_o)
        else $error("wakeup raised while running");

    rsv_inert_a: assert property ( // R20
        ((peripheral_source_mask | peripheral_wakeup_enable)
         & ~`SEC_SRC_VALID) == 29'h0)
        else $error("reserved source bit enabled");
endmodule
`default_nettype wire

/* verif/sec_core_model.sv */
`default_nettype none
module sec_core_model
(
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       req_i,
    input  wire logic       en_i,
    input  wire logic [3:0] slow_i,
    output logic            accept_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_cnt;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wait_cnt <= 4'h0;
            accept_o <= 1'b0;
        end
        else
        begin
            // a slow pipeline lets the request stand a while first
            accept_o <= en_i && req_i && !accept_o && wait_cnt >= slow_i;
            wait_cnt <= (req_i && !accept_o) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

/* verif/testbench.sv */
`include "sec_params.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import sec_pkg::*;
    logic        clk, rst_b, sup, gon, goff, ret, pd, en, wake, acc;
    logic [3:0]  slow;
    logic [6:0]  ded;
    logic [28:0] src;
    logic [31:0] rdata, x;
    logic [8:0]  ack;
    sec_bus_s    bus;
    sec_svc_s    svc;
    int          fails, checks, cyc, lat;
    localparam logic [31:0] V = {3'b0, `SEC_SRC_VALID};

    sec_ctrl dut_u (.ref_clk_i(clk), .rst_b_i(rst_b), .bus_i(bus),
        .rdata_o(rdata), .supervisor_i(sup), .src_i(src), .ded_evt_i(ded),
        .global_irq_on_instr_i(gon), .global_irq_off_instr_i(goff),
        .accept_i(acc), .return_i(ret), .powered_down_i(pd), .svc_o(svc),
        .gp_ack_o(ack), .wake_o(wake));
    sec_core_model core_u (.clk_i(clk), .rst_b_i(rst_b), .req_i(svc.req),
        .en_i(en), .slow_i(slow), .accept_o(acc));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] lf(input logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h0040_0007 : 32'h0);
    endfunction
    // expected input per source, reserved ids give 0
    function automatic int tgt(input int s);
        if (s == 1 || (s > 20 && s < 27)) return 0;
        if (s < 4) return 7;
        if (s < 8) return 8;
        if (s < 10) return 9;
        if (s < 14) return 10;
        if (s < 17) return 11;
        if (s < 19) return 12;
        if (s < 21) return 13;
        return s - 13;
    endfunction

    task automatic close_out;
        $display("fails=%0d checks=%0d", fails, checks);
        if (fails == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk(nm, e, rdata);
    endtask
    task automatic setsrc(input int s, input logic v);
        @(posedge clk);
        src[s] <= v;
    endtask
    task automatic pulse(input int w);
        @(posedge clk);
        if (w == 0) ret <= 1'b1; else if (w == 1) gon <= 1'b1;
        else goff <= 1'b1;
        @(posedge clk);
        {ret, gon, goff} <= 3'b000;
    endtask
    // polls a bounded number of edges for an acknowledge
    task automatic waitack(input logic [8:0] e);
        lat = 0;
        do
        begin
            @(posedge clk);
            #1 lat++;
        end while (ack === 9'h0 && lat < 30);
        chk("gp_ack", {23'b0, e}, {23'b0, ack});
    endtask
    task automatic fire(input int s, input logic [8:0] e);
        setsrc(s, 1'b1);
        waitack(e);
        setsrc(s, 1'b0);
        pulse(0);
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            close_out();
        end
    end

    initial
    begin
        {rst_b, gon, goff, ret, pd, slow, src, bus, ded} = '0;
        {sup, en} = 2'b11;
        fails = 0;
        checks = 0;
        x = 32'h25e4;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rdc("cmask", `SEC_ADDR_CMASK, 32'h0);
        rdc("pmask", `SEC_ADDR_PMASK, 32'h0);
        rdc("wake", `SEC_ADDR_WAKE, 32'h0);
        rdc("unmapped", 8'h30, 32'h0);
        repeat (4)
        begin
            // source mask clear while sources toggle: no stray latch bits
            x = lf(x);
            wr(`SEC_ADDR_WAKE, x);
            rdc("wake", `SEC_ADDR_WAKE, x & V);
            @(posedge clk) src <= x[28:0];
            rdc("state", `SEC_ADDR_PSTATE, x & V);
            @(posedge clk) src <= '0;
            x = lf(x);
            wr(`SEC_ADDR_PMASK, x);
            rdc("pmask", `SEC_ADDR_PMASK, x & V);
            wr(`SEC_ADDR_PMASK, 32'h0);
        end
        wr(`SEC_ADDR_PSTATE, 32'hffff_ffff);
        rdc("state_ro", `SEC_ADDR_PSTATE, 32'h0);
        wr(`SEC_ADDR_LATCH, 32'hffff_ffff);
        rdc("latch_ro", `SEC_ADDR_LATCH, 32'h0);
        wr(`SEC_ADDR_PMASK, 32'hffff_ffff);
        @(posedge clk) sup <= 1'b0;
        wr(`SEC_ADDR_PMASK, 32'h0);
        rdc("user_rd", `SEC_ADDR_PMASK, 32'h0);
        @(posedge clk) sup <= 1'b1;
        rdc("pmask", `SEC_ADDR_PMASK, V);
        @(posedge clk);
        #1 chk("rd_once", 32'h0, rdata);
        wr(`SEC_ADDR_WAKE, 32'h0);
        wr(`SEC_ADDR_CMASK, 32'h0000_ffff);
        wr(`SEC_ADDR_CTRL, 32'h1);
        for (int s = 0; s < 29; s++)
        begin
            slow <= 4'(s % 4);
            fire(s, tgt(s) == 0 ? 9'h0 : 9'h1 << (tgt(s) - 7));
            if (tgt(s) != 0) chk("latency", 1, {31'b0, lat >= 3});
        end
        @(posedge clk) src <= ~V[28:0];
        rdc("state_rsv", `SEC_ADDR_PSTATE, 32'h0);
        @(posedge clk) src <= '0;
        wr(`SEC_ADDR_ASSIGN0, 32'h0000_0008);
        fire(0, 9'h100);
        fire(4, 9'h001);
        wr(`SEC_ADDR_PMASK, ~32'h4);
        fire(2, 9'h0);
        wr(`SEC_ADDR_PMASK, 32'hffff_ffff);
        pulse(2);
        setsrc(3, 1'b1);
        waitack(9'h0);
        pulse(1);
        waitack(9'h001);
        setsrc(3, 1'b0);
        pulse(0);
        @(posedge clk) en <= 1'b0;
        @(posedge clk) src[8] <= 1'b1;
        src[14] <= 1'b1;
        repeat (3) @(posedge clk);
        rdc("latch", `SEC_ADDR_LATCH, 32'h0000_0a00);
        chk("cls", 32'd9, {28'b0, svc.cls});
        @(posedge clk) en <= 1'b1;
        waitack(9'h004);
        rdc("latch", `SEC_ADDR_LATCH, 32'h0000_0800);
        pulse(0);
        waitack(9'h010);
        setsrc(10, 1'b1);
        repeat (6) @(posedge clk);
        #1 chk("nest", 32'h018, {23'b0, ack});
        @(posedge clk) src <= '0;
        pulse(0);
        wr(`SEC_ADDR_WAKE, 32'h20);
        @(posedge clk) pd <= 1'b1;
        setsrc(6, 1'b1);
        repeat (3) @(posedge clk);
        #1 chk("wake_off", 32'h0, {31'b0, wake});
        setsrc(5, 1'b1);
        repeat (3) @(posedge clk);
        #1 chk("wake_on", 32'h1, {31'b0, wake});
        @(posedge clk) {pd, src} <= '0;
        pulse(2);
        @(posedge clk) ded <= 7'h60;
        repeat (2) @(posedge clk);
        #1 chk("ded_cls", 32'd5, {28'b0, svc.cls});
        @(posedge clk) ded <= 7'h00;
        repeat (4) pulse(0);
        close_out();
    end
endmodule
`default_nettype wire
